// ==== design/pwb_pkg.sv ====
package pwb_pkg;
  // register offsets
  localparam logic [2:0] PWB_OFF_STATUS = 3'h0;
  localparam logic [2:0] PWB_OFF_PERIOD = 3'h2;
  localparam logic [2:0] PWB_OFF_WIDTH = 3'h4;
  localparam logic [2:0] PWB_OFF_COUNT = 3'h6;
  localparam int PWB_DATA_W = 16;
  // status/control field positions
  localparam int PWB_FLAG_BIT = 15;
  localparam int PWB_IL_HI = 14;
  localparam int PWB_IL_LO = 12;
  localparam int PWB_IARB3_BIT = 11;
  localparam int PWB_PIN_BIT = 7;
  localparam int PWB_LOAD_BIT = 6;
  localparam int PWB_POL_BIT = 5;
  localparam int PWB_EN_BIT = 4;
  localparam int PWB_CLK_HI = 2;
  localparam int PWB_CLK_LO = 0;
  // reset and compare values
  localparam logic [15:0] PWB_COUNT_RESET = 16'h0001;
  localparam logic [15:0] PWB_WORD_ZERO = 16'h0000;
  localparam logic [2:0] PWB_IL_OFF = 3'h0;
  // enable-to-output delay, in tenths of a system clock
  localparam int PWB_TENTHS = 10;
  localparam int PWB_ENA_DIV2_MIN_TENTHS = 35;
  localparam int PWB_ENA_DIV3_MIN_TENTHS = 55;
  localparam logic [2:0] PWB_ENA_DIV2_CYC =
    3'((PWB_ENA_DIV2_MIN_TENTHS + PWB_TENTHS - 1) / PWB_TENTHS);
  localparam logic [2:0] PWB_ENA_DIV3_CYC =
    3'((PWB_ENA_DIV3_MIN_TENTHS + PWB_TENTHS - 1) / PWB_TENTHS);
  // divide-by-256 prescaler tap masks per clock select code
  localparam logic [7:0] PWB_DIV_MASK [8] = '{8'h00, 8'h01, 8'h03, 8'h07,
                                             8'h0F, 8'h1F, 8'h3F, 8'hFF};
  typedef enum logic [1:0] {
    PWB_ST_OFF,
    PWB_ST_ARM,
    PWB_ST_RUN
  } pwb_state_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } pwb_bus_type;
  typedef struct packed {
    logic [2:0] il;
    logic iarb3;
    logic output_polarity;
    logic en;
    logic [2:0] clk_sel;
  } pwb_ctrl_type;
endpackage

// ==== design/pwb_pwm_unit.sv ====
`timescale 1ns/1ps
// Overview of operation
// R01: clock select taps prescaler to documented rates
// R02: enabled: period copies to working at end
// R03: disabled: period copies to working next cycle
// R04: working period hidden from software
// R05: period applies next period or on load
// R06: hardware never alters user period
// R07: enabled: width copies to working at end
// R08: disabled: width copies to working next cycle
// R09: working width hidden from software
// R10: width applies next period or on load
// R11: hardware never alters user width
// R12: counter readable, writes ignored
// R13: counter one at reset and while disabled
// R14: pulses at least two system clocks
// R15: enable to output set 4 or 6 clocks
// R16: prescaler start to output set likewise
// R17: interrupt request one clock after flag
// R18: load restarts period with fresh values
// R19: disabled: output reset, prescaler held
// R20: flag set by hardware, read-then-write clears
// R21: counter advances, compares end period and pulse
module pwb_pwm_unit
  import pwb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire pwb_bus_type bus_in,
  output logic [15:0] rdata_out,
  input wire logic prescaler_running_in,
  input wire logic prescaler_two_or_three_in,
  input wire logic prescaler_first_output_in,
  output logic pwm_out,
  output logic irq_request_out,
  output logic [2:0] irq_level_out
);

  logic [15:0] user_period_q;
  logic [15:0] user_width_q;
  logic [15:0] working_period_q;
  logic [15:0] working_width_q;
  pwb_ctrl_type ctrl_q;
  logic flag_q;
  logic clr_arm_q;
  logic irq_q;
  logic [15:0] rdata_q;
  pwb_state_type state_q;
  pwb_state_type state_d;
  logic [2:0] delay_q;
  logic [2:0] delay_d;
  logic [7:0] prediv_q;
  logic [7:0] prediv_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic out_q;
  logic out_d;
  logic pin_q;
  logic period_start;
  logic reload;
  logic counter_tick;
  logic load_go;
  logic [2:0] ena_target;
  logic [7:0] tap_mask;
  logic wr_status;
  logic [15:0] status_word;

  // bus decode
  assign wr_status = bus_in.wr && (bus_in.addr == PWB_OFF_STATUS);
  assign load_go = wr_status && bus_in.wdata[PWB_LOAD_BIT]
                   && ctrl_q.en; // [R18]
  assign ena_target = prescaler_two_or_three_in ? PWB_ENA_DIV3_CYC
                                                : PWB_ENA_DIV2_CYC;
  assign tap_mask = PWB_DIV_MASK[ctrl_q.clk_sel];
  // counter clock: first prescaler output gated by selected tap
  assign counter_tick = (state_q == PWB_ST_RUN) && prescaler_first_output_in
                        && ((prediv_q & tap_mask) == tap_mask); // [R01]

  // user registers, written only by software
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_period_q <= PWB_WORD_ZERO;
      user_width_q <= PWB_WORD_ZERO;
    end else if (bus_in.wr) begin
      if (bus_in.addr == PWB_OFF_PERIOD) begin
        user_period_q <= bus_in.wdata; // [R06]
      end
      if (bus_in.addr == PWB_OFF_WIDTH) begin
        user_width_q <= bus_in.wdata; // [R11]
      end
    end
  end

  // control fields of the status/control register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q <= '0;
    end else if (wr_status) begin
      ctrl_q.il <= bus_in.wdata[PWB_IL_HI:PWB_IL_LO];
      ctrl_q.iarb3 <= bus_in.wdata[PWB_IARB3_BIT];
      ctrl_q.output_polarity <= bus_in.wdata[PWB_POL_BIT];
      ctrl_q.en <= bus_in.wdata[PWB_EN_BIT];
      ctrl_q.clk_sel <= bus_in.wdata[PWB_CLK_HI:PWB_CLK_LO];
    end
  end

  // hidden working copies, no bus path to them
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      working_period_q <= PWB_WORD_ZERO;
      working_width_q <= PWB_WORD_ZERO;
    end else if (reload) begin
      working_period_q <= user_period_q; // [R02] [R03] [R04] [R05]
      working_width_q <= user_width_q; // [R07] [R08] [R09] [R10]
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    delay_d = delay_q;
    prediv_d = prediv_q;
    count_d = count_q;
    out_d = out_q;
    period_start = 1'b0;
    reload = (state_q != PWB_ST_RUN); // [R03] [R08]
    case (state_q)
      PWB_ST_OFF: begin
        if (ctrl_q.en) begin
          state_d = PWB_ST_ARM;
        end
      end
      PWB_ST_ARM: begin
        // wait for a running prescaler, then a fixed latency
        if (prescaler_running_in) begin
          delay_d = delay_q + 3'h1;
          if (delay_q == ena_target - 3'h1) begin // [R15] [R16]
            state_d = PWB_ST_RUN;
            delay_d = 3'h0;
            out_d = 1'b1;
            period_start = 1'b1;
          end
        end
      end
      PWB_ST_RUN: begin
        if (prescaler_first_output_in) begin
          prediv_d = prediv_q + 8'h01;
        end
        if (counter_tick) begin
          if (count_q == working_period_q) begin // [R21]
            count_d = PWB_COUNT_RESET;
            out_d = (user_width_q != PWB_WORD_ZERO);
            period_start = 1'b1;
            reload = 1'b1; // [R02] [R07]
          end else begin
            count_d = count_q + 16'h0001; // [R21]
            // pulse spans whole counter clocks, two system clocks min
            if (count_q == working_width_q) begin // [R14]
              out_d = 1'b0;
            end
          end
        end
      end
      default: begin
        state_d = PWB_ST_OFF;
      end
    endcase
    if (load_go) begin
      state_d = PWB_ST_RUN; // [R18]
      delay_d = 3'h0;
      prediv_d = 8'h00;
      count_d = PWB_COUNT_RESET;
      out_d = (user_width_q != PWB_WORD_ZERO);
      period_start = 1'b1;
      reload = 1'b1; // [R05] [R10]
    end
    if (!ctrl_q.en) begin
      state_d = PWB_ST_OFF;
      delay_d = 3'h0;
      prediv_d = 8'h00; // [R19]
      count_d = PWB_COUNT_RESET; // [R13]
      out_d = 1'b0; // [R19]
      period_start = 1'b0;
    end
  end

  // sequencer, prescaler, counter and output flip-flop
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= PWB_ST_OFF;
      delay_q <= 3'h0;
      prediv_q <= 8'h00;
      count_q <= PWB_COUNT_RESET; // [R13]
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      delay_q <= delay_d;
      prediv_q <= prediv_d;
      count_q <= count_d;
      out_q <= out_d;
    end
  end

  // pin level: output flip-flop through polarity
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= out_d ^ ctrl_q.output_polarity; // [R19]
    end
  end

  // period flag: set wins over the software clear
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_q <= 1'b0;
      clr_arm_q <= 1'b0;
    end else if (period_start) begin
      flag_q <= 1'b1; // [R20]
      clr_arm_q <= 1'b0;
    end else if (wr_status) begin
      if (clr_arm_q && !bus_in.wdata[PWB_FLAG_BIT]) begin
        flag_q <= 1'b0; // [R20]
      end
      clr_arm_q <= 1'b0;
    end else if (bus_in.rd && bus_in.addr == PWB_OFF_STATUS && flag_q) begin
      clr_arm_q <= 1'b1;
    end
  end

  // interrupt request, one clock behind the flag
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q && (ctrl_q.il != PWB_IL_OFF); // [R17]
    end
  end

  // status word image; load reads as zero
  always_comb begin
    status_word = PWB_WORD_ZERO;
    status_word[PWB_FLAG_BIT] = flag_q;
    status_word[PWB_IL_HI:PWB_IL_LO] = ctrl_q.il;
    status_word[PWB_IARB3_BIT] = ctrl_q.iarb3;
    status_word[PWB_PIN_BIT] = pin_q;
    status_word[PWB_POL_BIT] = ctrl_q.output_polarity;
    status_word[PWB_EN_BIT] = ctrl_q.en;
    status_word[PWB_CLK_HI:PWB_CLK_LO] = ctrl_q.clk_sel;
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= PWB_WORD_ZERO;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        PWB_OFF_STATUS: rdata_q <= status_word;
        PWB_OFF_PERIOD: rdata_q <= user_period_q;
        PWB_OFF_WIDTH: rdata_q <= user_width_q;
        PWB_OFF_COUNT: rdata_q <= count_q; // [R12]
        default: rdata_q <= PWB_WORD_ZERO;
      endcase
    end else begin
      rdata_q <= PWB_WORD_ZERO;
    end
  end

  assign rdata_out = rdata_q;
  assign pwm_out = pin_q;
  assign irq_request_out = irq_q;
  assign irq_level_out = ctrl_q.il;

endmodule

// ==== testbench/pwb_pwm_chk.sv ====
`timescale 1ns/1ps
module pwb_pwm_chk
  import pwb_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire pwb_bus_type bus_in,
  input wire logic [15:0] rdata_out,
  input wire logic prescaler_running_in,
  input wire logic prescaler_two_or_three_in,
  input wire logic prescaler_first_output_in,
  input wire logic pwm_out,
  input wire logic irq_request_out,
  input wire logic [2:0] irq_level_out
);
  logic en_q;
  logic en2_q;
  logic pol_q;
  logic [2:0] il_q;
  // shadow of written control bits
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_q <= 1'b0;
      en2_q <= 1'b0;
      pol_q <= 1'b0;
      il_q <= 3'h0;
    end else begin
      en2_q <= en_q;
      if (bus_in.wr && bus_in.addr == PWB_OFF_STATUS) begin
        en_q <= bus_in.wdata[PWB_EN_BIT];
        pol_q <= bus_in.wdata[PWB_POL_BIT];
        il_q <= bus_in.wdata[PWB_IL_HI:PWB_IL_LO];
      end
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  rd_idle_a: assert property (
    !$past(bus_in.rd) |-> rdata_out == 16'h0000) else $error("stray data");
  odd_read_a: assert property (
    $past(bus_in.rd && bus_in.addr[0]) |-> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  cnt_hold_a: assert property (
    $past(bus_in.rd && bus_in.addr == PWB_OFF_COUNT && !en_q && !en2_q)
    |-> rdata_out == PWB_COUNT_RESET) else $error("counter not one");
  pol_idle_a: assert property (
    !en_q && !en2_q && $stable(pol_q) |-> pwm_out == pol_q)
    else $error("idle level wrong");
  en_div2_a: assert property (
    $rose(en_q) && prescaler_running_in && !prescaler_two_or_three_in
    |-> (pwm_out == pol_q)[*3] ##[1:3] pwm_out != pol_q)
    else $error("enable latency by two");
  en_div3_a: assert property (
    $rose(en_q) && prescaler_running_in && prescaler_two_or_three_in
    |-> (pwm_out == pol_q)[*5] ##[1:3] pwm_out != pol_q)
    else $error("enable latency by three");
  il_field_a: assert property (
    irq_level_out == il_q) else $error("level field wrong");
  irq_lvl_a: assert property (
    irq_request_out |-> $past(irq_level_out) != PWB_IL_OFF)
    else $error("request at level zero");
endmodule
bind pwb_pwm_unit pwb_pwm_chk u_chk (
  .clock_in(clock_in),
  .rstn_in(rstn_in),
  .bus_in(bus_in),
  .rdata_out(rdata_out),
  .prescaler_running_in(prescaler_running_in),
  .prescaler_two_or_three_in(prescaler_two_or_three_in),
  .prescaler_first_output_in(prescaler_first_output_in),
  .pwm_out(pwm_out),
  .irq_request_out(irq_request_out),
  .irq_level_out(irq_level_out)
);

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import pwb_pkg::*;
;
  typedef struct {
    logic w;
    logic [2:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } pwb_row_type;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  pwb_bus_type b = '0;
  logic div3 = 1'b0;
  logic run = 1'b1;
  logic tick = 1'b0;
  logic [1:0] pc = 2'h0;
  logic [15:0] rdata;
  logic [15:0] s;
  logic pwm;
  logic irq;
  logic seen_hi;
  logic [2:0] lvl;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int h;
  int p;
  pwb_row_type rows [9] = '{
    '{1'b0, 3'h6, 16'h0, 16'h0001},
    '{1'b1, 3'h6, 16'h1234, 16'h0}, '{1'b0, 3'h6, 16'h0, 16'h0001},
    '{1'b1, 3'h2, 16'h0004, 16'h0}, '{1'b0, 3'h2, 16'h0, 16'h0004},
    '{1'b1, 3'h4, 16'h0002, 16'h0}, '{1'b0, 3'h4, 16'h0, 16'h0002},
    '{1'b0, 3'h5, 16'h0, 16'h0}, '{1'b0, 3'h0, 16'h0, 16'h0}};
  pwb_pwm_unit u_dut (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .bus_in(b),
    .rdata_out(rdata),
    .prescaler_running_in(run),
    .prescaler_two_or_three_in(div3),
    .prescaler_first_output_in(tick),
    .pwm_out(pwm),
    .irq_request_out(irq),
    .irq_level_out(lvl)
  );
  // system clock
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  // first prescaler stage pulse, every two or three clocks
  always @(posedge clock_in) begin
    pc <= (pc >= (div3 ? 2'h2 : 2'h1)) ? 2'h0 : pc + 2'h1;
    tick <= (pc == 2'h0);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    b <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    b.wr <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [2:0] a);
    b <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
    @(posedge clock_in);
    b.rd <= 1'b0;
    #1 s = rdata;
    @(posedge clock_in);
  endtask
  // one output period: high time and period in clocks
  task automatic per();
    longint t0;
    @(posedge pwm);
    t0 = $time;
    @(negedge pwm);
    h = int'(($time - t0) / 10);
    @(posedge pwm);
    p = int'(($time - t0) / 10);
  endtask
  task automatic final_report();
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a);
        chk("reg", rows[i].e, s);
      end
    end
    for (int k = 0; k < 8; k++) begin
      wr(PWB_OFF_STATUS, 16'h1010 | 16'(k));
      per();
      per();
      chk("period", 16'(4 * (k == 7 ? 512 : 2 << k)), 16'(p));
      chk("high_min", 16'h1, {15'h0, h >= 2});
    end
    rd(PWB_OFF_STATUS);
    chk("flag", 16'h8000, s & 16'h8000);
    chk("irq", 16'h1, {15'h0, irq});
    wr(PWB_OFF_STATUS, 16'h1010);
    wr(PWB_OFF_PERIOD, 16'h0006);
    per();
    per();
    chk("new_period", 16'h000C, 16'(p));
    wr(PWB_OFF_WIDTH, 16'h0000);
    wr(PWB_OFF_STATUS, 16'h1050);
    seen_hi = 1'b0;
    repeat (30) begin
      @(negedge clock_in);
      seen_hi = seen_hi | pwm;
    end
    @(posedge clock_in);
    chk("load_zero", 16'h0, {15'h0, seen_hi});
    wr(PWB_OFF_STATUS, 16'h1000);
    rd(PWB_OFF_STATUS);
    chk("flag_kept", 16'h9000, s);
    wr(PWB_OFF_STATUS, 16'h0000);
    rd(PWB_OFF_STATUS);
    chk("flag_clear", 16'h0, s);
    chk("irq_off", 16'h0, {15'h0, irq});
    div3 <= 1'b1;
    wr(PWB_OFF_STATUS, 16'h0020);
    wr(PWB_OFF_WIDTH, 16'h0002);
    wr(PWB_OFF_STATUS, 16'h1030);
    per();
    per();
    chk("div3_period", 16'h0012, 16'(p));
    // mid-run reset, then enable while the prescaler is stopped
    rstn_in <= 1'b0;
    run <= 1'b0;
    div3 <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    chk("rst_pwm", 16'h0, {15'h0, pwm});
    chk("rst_irq", 16'h0, {15'h0, irq});
    rd(PWB_OFF_COUNT);
    chk("rst_count", 16'h0001, s);
    rd(PWB_OFF_STATUS);
    chk("rst_status", 16'h0, s);
    wr(PWB_OFF_STATUS, 16'h0010);
    repeat (8) @(posedge clock_in);
    chk("held", 16'h0, {15'h0, pwm});
    run <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    chk("run_early", 16'h0, {15'h0, pwm});
    @(posedge clock_in);
    #1;
    chk("run_set", 16'h1, {15'h0, pwm});
    @(posedge clock_in);
    final_report();
  end
endmodule
